// [include/crm_pkg.sv]
package crm_pkg;

    // ========================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    // backplane reset hold after power-up or soft reset
    localparam int unsigned RST_HOLD_NS   = 1000000;
    // satellite polling interval of the backplane reset
    localparam int unsigned POLL_NS       = 10000000;
    // reissue interval of a standing thermal alert
    localparam int unsigned ALERT_NS      = 1000000000;
    localparam int unsigned RST_HOLD_CYC  =
        (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned POLL_CYC      = POLL_NS / CLK_PERIOD_NS;
    localparam int unsigned ALERT_CYC     = ALERT_NS / CLK_PERIOD_NS;
    // settle time of the synchronisers before the role is sampled
    localparam logic [31:0] SYNC_WAIT     = 32'h0000_0003;
    localparam logic [31:0] CNT_ONE       = 32'h0000_0001;
    localparam logic [31:0] CNT_ZERO      = 32'h0000_0000;

    // ========================================
    // register map
    localparam logic [3:0] ADDR_CTRL      = 4'h0;
    localparam logic [3:0] ADDR_MODE_NEXT = 4'h1;
    localparam logic [3:0] ADDR_MODE_NOW  = 4'h2;
    localparam logic [3:0] ADDR_WARN      = 4'h3;
    localparam logic [3:0] ADDR_SHUT      = 4'h4;
    localparam logic [3:0] ADDR_TEMP      = 4'h5;
    localparam logic [3:0] ADDR_STATUS    = 4'h6;
    localparam logic [3:0] ADDR_MASK      = 4'h7;
    localparam logic [3:0] ADDR_FLASH     = 4'h8;

    localparam int CTRL_SOFT_RST = 0;
    localparam int MODE_NOW_SYS  = 2;

    // ========================================
    // reset operating modes
    localparam logic [1:0] MODE_11      = 2'h1;
    localparam logic [1:0] MODE_22      = 2'h2;
    localparam logic [1:0] MODE_66      = 2'h3;
    localparam logic [1:0] MODE_DEFAULT = MODE_66;

    // ========================================
    // thresholds
    localparam logic [7:0] WARN_RST = 8'h50;
    localparam logic [7:0] SHUT_RST = 8'h5A;

    // ========================================
    // status bits
    localparam int STAT_W       = 4;
    localparam int STAT_WARN    = 0;
    localparam int STAT_CRIT    = 1;
    localparam int STAT_SATRST  = 2;
    localparam int STAT_REFUSED = 3;

    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_WARN = 2'h1;
    localparam logic [1:0] LVL_CRIT = 2'h2;

    typedef enum logic [1:0] {
        ST_CAPTURE,
        ST_RESET,
        ST_RUN
    } crm_seq_t;

endpackage : crm_pkg

// [logic/crm_sync2.sv]
`timescale 1ns/1ps
module crm_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // ========================================
    // two-stage synchroniser, first stage read only by second
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } crm_sync_t;

    crm_sync_t q_s;
    crm_sync_t next_q_s;

    always_comb begin
        next_q_s    = q_s;
        next_q_s.s1 = d;
        next_q_s.s2 = q_s.s1;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q_s <= '1;
        end else if (clk_en) begin
            q_s <= next_q_s;
        end
    end

    assign q = q_s.s2;

endmodule : crm_sync2

// [logic/crm_reset_thermal.sv]
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module crm_reset_thermal #(
    parameter int unsigned RST_HOLD_CYC = crm_pkg::RST_HOLD_CYC,
    parameter int unsigned POLL_CYC     = crm_pkg::POLL_CYC,
    parameter int unsigned ALERT_CYC    = crm_pkg::ALERT_CYC
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       sysen_b,
    input  wire logic       bp_rst_b_in,
    output logic            bp_rst_b_out,
    output logic            bp_rst_b_oe,
    output logic            pci_clk_en,
    output logic            pci_isolate,
    output logic            bridge_rst_b,
    output logic            cpu_rst_b,
    input  wire logic [1:0] cfg_mode,
    input  wire logic       cfg_valid,
    output logic      [1:0] mode_store,
    input  wire logic       boot_image,
    input  wire logic [7:0] temp,
    output logic            alert_warn,
    output logic            alert_crit,
    output logic      [7:0] alert_thresh,
    output logic      [7:0] alert_temp,
    output logic            flash_req,
    output logic      [7:0] flash_data,
    output logic            irq
);

    // ========================================
    // state
    typedef struct packed {
        crm_pkg::crm_seq_t          seq;
        logic                       sys_slot;
        logic [1:0]                 mode;
        logic [1:0]                 mode_next;
        logic [7:0]                 warn_sh;
        logic [7:0]                 shut_sh;
        logic [7:0]                 warn_t;
        logic [7:0]                 shut_t;
        logic [31:0]                seq_cnt;
        logic [31:0]                poll_cnt;
        logic [31:0]                alert_cnt;
        logic [1:0]                 lvl;
        logic [crm_pkg::STAT_W-1:0] status;
        logic [crm_pkg::STAT_W-1:0] mask;
        logic [7:0]                 rdata;
        logic                       irq;
        logic                       bp_rst_out;
        logic                       bp_rst_oe;
        logic                       pci_clk_en;
        logic                       pci_isolate;
        logic                       bridge_rst_b;
        logic                       cpu_rst_b;
        logic                       alert_warn;
        logic                       alert_crit;
        logic [7:0]                 alert_thresh;
        logic [7:0]                 alert_temp;
        logic                       flash_req;
        logic [7:0]                 flash_data;
    } crm_regs_t;

    crm_regs_t q;
    crm_regs_t next_q;

    logic       pci_rst_s;
    logic       sysen_s;
    logic [1:0] lvl_now;
    logic       refused;
    logic [crm_pkg::STAT_W-1:0] stat_set;
    logic [crm_pkg::STAT_W-1:0] stat_clr;

    // ========================================
    // helpers
    function automatic logic pci_active(input logic [1:0] mode,
                                        input logic       sys);
        pci_active = sys ? (mode != crm_pkg::MODE_22)
                         : (mode == crm_pkg::MODE_11);
    endfunction : pci_active

    function automatic logic [1:0] temp_level(input logic [7:0] t,
                                              input logic [7:0] warn,
                                              input logic [7:0] shut);
        if (t >= shut) begin
            temp_level = crm_pkg::LVL_CRIT;
        end else if (t >= warn) begin
            temp_level = crm_pkg::LVL_WARN;
        end else begin
            temp_level = crm_pkg::LVL_NONE;
        end
    endfunction : temp_level

    function automatic logic [1:0] legal_mode(input logic [1:0] m);
        legal_mode = (m == 2'h0) ? crm_pkg::MODE_DEFAULT : m;
    endfunction : legal_mode

    // ========================================
    // backplane input synchronisers
    crm_sync2 #(
        .W (2)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .d       ({bp_rst_b_in, sysen_b}),
        .q       ({pci_rst_s, sysen_s})
    );

    // ========================================
    // next state
    always_comb begin
        next_q            = q;
        next_q.flash_req  = 1'b0;
        next_q.alert_warn = 1'b0;
        next_q.alert_crit = 1'b0;
        next_q.rdata      = 8'h00;
        stat_set          = '0;
        stat_clr          = '0;
        lvl_now           = temp_level(temp, q.warn_t, q.shut_t);

        // reset sequencer; a backplane reset loads warn_t and shut_t from the shadows, other registers survive it
        case (q.seq)
            crm_pkg::ST_CAPTURE: begin
                if (q.seq_cnt == crm_pkg::SYNC_WAIT) begin
                    next_q.sys_slot = !sysen_s;
                    // mode latched only here, after power-up
                    if (cfg_valid) begin
                        next_q.mode = legal_mode(cfg_mode);
                    end else begin
                        next_q.mode = crm_pkg::MODE_DEFAULT;
                    end
                    next_q.mode_next = next_q.mode;
                    next_q.seq       = crm_pkg::ST_RESET;
                    next_q.seq_cnt   = crm_pkg::CNT_ZERO;
                end else begin
                    next_q.seq_cnt = q.seq_cnt + crm_pkg::CNT_ONE;
                end
            end
            crm_pkg::ST_RESET: begin
                next_q.warn_t = q.warn_sh;
                next_q.shut_t = q.shut_sh;
                if (q.seq_cnt >= 32'(RST_HOLD_CYC - 1)) begin
                    next_q.seq     = crm_pkg::ST_RUN;
                    next_q.seq_cnt = crm_pkg::CNT_ZERO;
                end else begin
                    next_q.seq_cnt = q.seq_cnt + crm_pkg::CNT_ONE;
                end
            end
            crm_pkg::ST_RUN: begin
                if (q.poll_cnt >= 32'(POLL_CYC - 1)) begin
                    next_q.poll_cnt = crm_pkg::CNT_ZERO;
                    if (!q.sys_slot && !pci_rst_s) begin
                        next_q.seq     = crm_pkg::ST_RESET;
                        next_q.seq_cnt = crm_pkg::CNT_ZERO;
                        stat_set[crm_pkg::STAT_SATRST] = 1'b1;
                    end
                end else begin
                    next_q.poll_cnt = q.poll_cnt + crm_pkg::CNT_ONE;
                end
            end
            default: begin
                next_q.seq     = crm_pkg::ST_CAPTURE;
                next_q.seq_cnt = crm_pkg::CNT_ZERO;
            end
        endcase

        // thermal alerts, repeated while the level stands
        next_q.lvl = lvl_now;
        if (lvl_now != crm_pkg::LVL_NONE &&
            (lvl_now != q.lvl || q.alert_cnt == crm_pkg::CNT_ZERO)) begin
            next_q.alert_cnt  = 32'(ALERT_CYC - 1);
            next_q.alert_warn = (lvl_now == crm_pkg::LVL_WARN);
            next_q.alert_crit = (lvl_now == crm_pkg::LVL_CRIT);
            next_q.alert_thresh = next_q.alert_crit ? q.shut_t
                                                    : q.warn_t;
            next_q.alert_temp   = temp;
            stat_set[crm_pkg::STAT_WARN] = next_q.alert_warn;
            stat_set[crm_pkg::STAT_CRIT] = next_q.alert_crit;
        end else if (lvl_now == crm_pkg::LVL_NONE) begin
            next_q.alert_cnt = crm_pkg::CNT_ZERO;
        end else begin
            next_q.alert_cnt = q.alert_cnt - crm_pkg::CNT_ONE;
        end

        // register writes; boot image takes only flash updates
        refused = boot_image && reg_wr && reg_addr != crm_pkg::ADDR_FLASH;
        if (refused) begin
            stat_set[crm_pkg::STAT_REFUSED] = 1'b1;
        end
        if (reg_wr && !refused) begin
            case (reg_addr)
                crm_pkg::ADDR_CTRL: begin
                    if (reg_wdata[crm_pkg::CTRL_SOFT_RST] &&
                        q.seq == crm_pkg::ST_RUN) begin
                        next_q.seq     = crm_pkg::ST_RESET;
                        next_q.seq_cnt = crm_pkg::CNT_ZERO;
                    end
                end
                crm_pkg::ADDR_MODE_NEXT: begin
                    next_q.mode_next = legal_mode(reg_wdata[1:0]);
                end
                crm_pkg::ADDR_WARN: begin
                    next_q.warn_sh = reg_wdata;
                end
                crm_pkg::ADDR_SHUT: begin
                    next_q.shut_sh = reg_wdata;
                end
                crm_pkg::ADDR_MASK: begin
                    next_q.mask = reg_wdata[crm_pkg::STAT_W-1:0];
                end
                crm_pkg::ADDR_FLASH: begin
                    next_q.flash_req  = 1'b1;
                    next_q.flash_data = reg_wdata;
                end
                default: begin
                end
            endcase
        end

        // register reads; status clears on read
        if (reg_rd) begin
            case (reg_addr)
                crm_pkg::ADDR_MODE_NEXT: next_q.rdata = {6'h00, q.mode_next};
                crm_pkg::ADDR_MODE_NOW: begin
                    next_q.rdata = {5'h00, q.sys_slot, q.mode};
                end
                crm_pkg::ADDR_WARN:   next_q.rdata = q.warn_sh;
                crm_pkg::ADDR_SHUT:   next_q.rdata = q.shut_sh;
                crm_pkg::ADDR_TEMP:   next_q.rdata = temp;
                crm_pkg::ADDR_STATUS: begin
                    next_q.rdata = {4'h0, q.status};
                    stat_clr     = '1;
                end
                crm_pkg::ADDR_MASK:   next_q.rdata = {4'h0, q.mask};
                default:              next_q.rdata = 8'h00;
            endcase
        end
        // set wins over a clear in the same cycle
        next_q.status = (q.status & ~stat_clr) | stat_set;
        next_q.irq    = |(next_q.status & next_q.mask);

        // backplane and local reset outputs
        next_q.bp_rst_out = 1'b0;
        next_q.bp_rst_oe  = next_q.sys_slot &&
                            (next_q.seq == crm_pkg::ST_RESET ||
                             next_q.mode == crm_pkg::MODE_22);
        next_q.pci_clk_en = next_q.sys_slot &&
                            next_q.seq != crm_pkg::ST_CAPTURE &&
                            next_q.mode != crm_pkg::MODE_22;
        next_q.pci_isolate = next_q.seq == crm_pkg::ST_CAPTURE ||
                    !pci_active(next_q.mode, next_q.sys_slot);
        next_q.bridge_rst_b = next_q.seq == crm_pkg::ST_RUN &&
                    pci_active(next_q.mode, next_q.sys_slot) &&
                    (next_q.sys_slot || pci_rst_s);
        next_q.cpu_rst_b = next_q.seq == crm_pkg::ST_RUN &&
                    !(!next_q.sys_slot &&
                      next_q.mode == crm_pkg::MODE_11 &&
                      !pci_rst_s);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q             <= '0;
            q.mode        <= crm_pkg::MODE_DEFAULT;
            q.mode_next   <= crm_pkg::MODE_DEFAULT;
            q.warn_sh     <= crm_pkg::WARN_RST;
            q.shut_sh     <= crm_pkg::SHUT_RST;
            q.warn_t      <= crm_pkg::WARN_RST;
            q.shut_t      <= crm_pkg::SHUT_RST;
            q.pci_isolate <= 1'b1;
        end else if (clk_en) begin
            q <= next_q;
        end
    end

    // ========================================
    // outputs
    assign reg_rdata    = q.rdata;
    assign bp_rst_b_out = q.bp_rst_out;
    assign bp_rst_b_oe  = q.bp_rst_oe;
    assign pci_clk_en   = q.pci_clk_en;
    assign pci_isolate  = q.pci_isolate;
    assign bridge_rst_b = q.bridge_rst_b;
    assign cpu_rst_b    = q.cpu_rst_b;
    assign mode_store   = q.mode_next;
    assign alert_warn   = q.alert_warn;
    assign alert_crit   = q.alert_crit;
    assign alert_thresh = q.alert_thresh;
    assign alert_temp   = q.alert_temp;
    assign flash_req    = q.flash_req;
    assign flash_data   = q.flash_data;
    assign irq          = q.irq;

    // ========================================
    // checks
    role_sample_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (clk_en && q.seq == crm_pkg::ST_CAPTURE &&
         q.seq_cnt == crm_pkg::SYNC_WAIT)
        |=> q.sys_slot == !$past(sysen_s))
        else $error("slot role not taken from system enable");

    sys_normal_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (clk_en && q.seq == crm_pkg::ST_RUN && q.sys_slot &&
         q.mode != crm_pkg::MODE_22)
        |=> pci_clk_en && !pci_isolate &&
            (bp_rst_b_oe == (q.seq == crm_pkg::ST_RESET)))
        else $error("system slot not driving normal reset and clock");

    sat_forward_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (clk_en && q.seq == crm_pkg::ST_RUN && !q.sys_slot &&
         q.mode == crm_pkg::MODE_11 && !pci_rst_s)
        |=> !bridge_rst_b && !cpu_rst_b)
        else $error("backplane reset not forwarded");

    sys_standalone_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (clk_en && q.seq != crm_pkg::ST_CAPTURE && q.sys_slot &&
         q.mode == crm_pkg::MODE_22)
        |=> bp_rst_b_oe && !bp_rst_b_out && !pci_clk_en && pci_isolate)
        else $error("standalone system slot not holding reset");

    sat_isolate_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (clk_en && q.seq != crm_pkg::ST_CAPTURE && !q.sys_slot &&
         q.mode != crm_pkg::MODE_11)
        |=> !bridge_rst_b && pci_isolate && !bp_rst_b_oe)
        else $error("satellite bridge not isolated");

    mode_default_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (clk_en && q.seq == crm_pkg::ST_CAPTURE &&
         q.seq_cnt == crm_pkg::SYNC_WAIT && !cfg_valid)
        |=> q.mode == crm_pkg::MODE_66)
        else $error("default mode not selected");

    mode_hold_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (q.seq != crm_pkg::ST_CAPTURE) |=> $stable(q.mode))
        else $error("active mode changed without power cycle");

    sat_poll_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (clk_en && q.seq == crm_pkg::ST_RUN && !q.sys_slot &&
         !pci_rst_s && q.poll_cnt == 32'(POLL_CYC - 1))
        |=> q.seq == crm_pkg::ST_RESET && !cpu_rst_b &&
            q.status[crm_pkg::STAT_SATRST])
        else $error("polled backplane reset did not reset board");

    warn_alert_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (clk_en && temp >= q.warn_t && temp < q.shut_t &&
         q.lvl == crm_pkg::LVL_NONE)
        |=> alert_warn && !alert_crit && alert_thresh == $past(q.warn_t))
        else $error("warning alert missing");

    crit_alert_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (clk_en && temp >= q.shut_t && q.lvl != crm_pkg::LVL_CRIT)
        |=> alert_crit && !alert_warn && alert_temp == $past(temp))
        else $error("critical alert missing");

    alert_repeat_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (clk_en && q.lvl != crm_pkg::LVL_NONE && lvl_now == q.lvl &&
         q.alert_cnt == crm_pkg::CNT_ZERO)
        |=> (alert_warn || alert_crit) &&
            q.alert_cnt == 32'(ALERT_CYC - 1))
        else $error("standing alert not reissued");

    thresh_defer_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (q.seq == crm_pkg::ST_RUN) |=> $stable(q.warn_t) &&
                                         $stable(q.shut_t))
        else $error("threshold changed outside reset");

    boot_refuse_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (clk_en && boot_image && reg_wr &&
         reg_addr == crm_pkg::ADDR_MODE_NEXT)
        |=> $stable(q.mode_next) && q.status[crm_pkg::STAT_REFUSED])
        else $error("command accepted while on boot image");

endmodule : crm_reset_thermal

// [verification/crm_host_model.sv]
`timescale 1ns/1ps
// ========
// backplane and host board as seen from one slot
module crm_host_model (
    input  wire logic sys_slot,
    input  wire logic host_rst,
    input  wire logic dut_oe,
    input  wire logic dut_out,
    output logic      sysen_b,
    output logic      bp_rst_b_in
);
    // slot wiring grounds the enable only in the system slot
    assign sysen_b     = !sys_slot;
    // open-drain wire with pull-up, pulled low while host_rst is high or the slot drives it low
    assign bp_rst_b_in = !(host_rst || (dut_oe && !dut_out));
endmodule : crm_host_model

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    logic       clk_sys, rst_b, clk_en, reg_wr, reg_rd, cfg_valid;
    logic       sys_slot, host_rst, boot_image, sysen_b, bp_rst_b_in;
    logic       bp_rst_b_out, bp_rst_b_oe, pci_clk_en, pci_isolate;
    logic       bridge_rst_b, cpu_rst_b, alert_warn, alert_crit;
    logic       flash_req, irq;
    logic [1:0] cfg_mode, mode_store;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, temp, rd_v, t_v;
    logic [7:0] alert_thresh, alert_temp, flash_data;
    int         n_mismatch, cmp_count, cyc;

    crm_reset_thermal #(.RST_HOLD_CYC(8), .POLL_CYC(16), .ALERT_CYC(32))
    dut (.clk_sys, .rst_b, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .sysen_b, .bp_rst_b_in, .bp_rst_b_out,
        .bp_rst_b_oe, .pci_clk_en, .pci_isolate, .bridge_rst_b,
        .cpu_rst_b, .cfg_mode, .cfg_valid, .mode_store, .boot_image,
        .temp, .alert_warn, .alert_crit, .alert_thresh, .alert_temp,
        .flash_req, .flash_data, .irq);
    crm_host_model bp (.sys_slot, .host_rst, .dut_oe(bp_rst_b_oe),
        .dut_out(bp_rst_b_out), .sysen_b, .bp_rst_b_in);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ========
    // tasks
    function automatic logic [7:0] pins(input logic sys,
                                        input logic [1:0] m);
        if (sys) return (m == crm_pkg::MODE_22) ? 8'h03 : 8'h04;
        return (m == crm_pkg::MODE_11) ? 8'h01 : 8'h02;
    endfunction : pins

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    task automatic wait_for(ref logic s, input logic v);
        for (cyc = 1; cyc <= 300; cyc++) begin
            @(posedge clk_sys);
            #1;
            if (s === v) return;
        end
        n_mismatch++;
        conclude();
    endtask : wait_for

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 rd_v = reg_rdata;
    endtask : rd

    task automatic power(input logic s, input logic [1:0] m, input logic v);
        @(posedge clk_sys);
        sys_slot  <= s;
        cfg_mode  <= m;
        cfg_valid <= v;
        rst_b     <= 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_b     <= 1'b1;
        wait_for(cpu_rst_b, 1'b1);
    endtask : power

    // ========
    // sequence
    initial begin
        {clk_en, rst_b, reg_wr, reg_rd, host_rst, boot_image} = 6'h20;
        {reg_addr, reg_wdata, temp, cfg_mode, cfg_valid} = '0;
        sys_slot   = 1'b1;
        n_mismatch = 0;
        cmp_count  = 0;
        void'($urandom(32'h804f));
        for (int s = 0; s < 2; s++) begin
            for (int m = 1; m < 4; m++) begin
                power(s[0], m[1:0], 1'b1);
                rd(crm_pkg::ADDR_MODE_NOW);
                chk(rd_v, {5'h0, s[0], m[1:0]});
                t_v = s ? {4'h0, bp_rst_b_out, pci_clk_en, pci_isolate,
                           bp_rst_b_oe}
                        : {6'h0, pci_isolate, bridge_rst_b};
                chk(t_v, pins(s[0], m[1:0]));
            end
        end
        power(1'b0, crm_pkg::MODE_11, 1'b1);
        wr(crm_pkg::ADDR_MASK, 8'h04);
        host_rst <= 1'b1;
        wait_for(cpu_rst_b, 1'b0);
        chk({7'h0, bridge_rst_b}, 8'h00);
        // host keeps reset low past one poll period
        repeat (20) @(posedge clk_sys);
        host_rst <= 1'b0;
        wait_for(cpu_rst_b, 1'b1);
        rd(crm_pkg::ADDR_STATUS);
        chk(rd_v & 8'h04, 8'h04);
        rd(crm_pkg::ADDR_MASK);
        chk(rd_v, 8'h04);
        power(1'b1, 2'h0, 1'b0);
        rd(crm_pkg::ADDR_MODE_NOW);
        chk(rd_v, 8'h07);
        wr(crm_pkg::ADDR_MODE_NEXT, 8'h01);
        wr(crm_pkg::ADDR_WARN, 8'h30);
        t_v = 8'($urandom_range(8'h4f, 8'h30));
        temp <= t_v;
        repeat (40) @(posedge clk_sys);
        rd(crm_pkg::ADDR_STATUS);
        chk(rd_v & 8'h03, 8'h00);
        wr(crm_pkg::ADDR_CTRL, 8'h01);
        wait_for(alert_warn, 1'b1);
        wait_for(alert_warn, 1'b0);
        wait_for(alert_warn, 1'b1);
        chk(8'(cyc), 8'h1f);
        chk(alert_thresh, 8'h30);
        chk(alert_temp, t_v);
        chk({6'h0, mode_store}, 8'h01);
        rd(crm_pkg::ADDR_MODE_NOW);
        chk(rd_v, 8'h07);
        wr(crm_pkg::ADDR_MODE_NEXT, 8'h00);
        wr(crm_pkg::ADDR_MASK, 8'h02);
        temp <= 8'h5a;
        wait_for(alert_crit, 1'b1);
        chk({6'h0, mode_store}, 8'h03);
        chk(alert_thresh, crm_pkg::SHUT_RST);
        chk(alert_temp, 8'h5a);
        wait_for(irq, 1'b1);
        rd(crm_pkg::ADDR_STATUS);
        chk(rd_v & 8'h02, 8'h02);
        wait_for(irq, 1'b0);
        @(posedge clk_sys);
        clk_en <= 1'b0;
        wr(crm_pkg::ADDR_MASK, 8'h0f);
        clk_en <= 1'b1;
        rd(crm_pkg::ADDR_MASK);
        chk(rd_v, 8'h02); // write dropped while frozen
        boot_image <= 1'b1;
        wr(crm_pkg::ADDR_SHUT, 8'h11);
        wr(crm_pkg::ADDR_MODE_NEXT, 8'h02);
        wr(crm_pkg::ADDR_FLASH, 8'ha5);
        #1 chk({7'h0, flash_req}, 8'h01);
        chk(flash_data, 8'ha5);
        chk({6'h0, mode_store}, 8'h03);
        rd(crm_pkg::ADDR_SHUT);
        chk(rd_v, crm_pkg::SHUT_RST);
        rd(crm_pkg::ADDR_STATUS);
        chk(rd_v & 8'h08, 8'h08);
        rd(4'hf);
        chk(rd_v, 8'h00);
        conclude();
    end
endmodule : tb_top
